// ### design/uart_host_port_modem_pins.sv
// Purpose: Host parallel port, modem pins and channel interrupts, 4 channels
// Assumes: Strobes and pins synchronous to clk_sys_i; device reset active high
// Notes: Serializer omitted; received bytes enter through rx_byte ports
`timescale 1ns/100ps
// What this block does
// RULE1 - Eight-bit three-state data bus, bit0 LSB
// RULE2 - Control bit0 set drives terminal-ready low
// RULE3 - Terminal-ready may drive RS-485 transceiver enable
// RULE4 - Interrupt needs enable bit, source enable, condition
// RULE5 - Sources: errors, rx data, tx empty, modem
// RULE6 - Interrupt outputs high impedance after reset
// RULE7 - Force pin drives interrupts regardless of bit3
// RULE8 - Read strobe low drives selected register
// RULE9 - Write strobe low stores bus into register
// RULE10 - Reset clears registers, disables serial pins
// RULE11 - Ring rising edge raises modem status interrupt
// RULE12 - Control bit1 set drives request-to-send low
// RULE13 - Request-to-send affects flow only with auto-RTS
// RULE14 - Loopback ignores receive pin, routes transmit back
// RULE15 - Far end idles receive line high
// RULE16 - Combined receive-ready low on trigger, wired-OR
// RULE17 - Host selects channel by its select low
// RULE18 - Interrupt drops when nothing enabled remains pending
module uart_host_port_modem_pins
    import quad_port_pkg::*;
#(
    parameter int NUM = NUM_CH,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and resets
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic device_reset_i,
    // Host parallel port
    input wire logic [NUM-1:0] channel_select_n_i,
    input wire logic [ADDR_W-1:0] reg_select_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [DATA_W-1:0] data_bus_i,
    output logic [DATA_W-1:0] data_bus_o,
    output logic data_bus_oe_o,
    // Serial and modem pins per channel
    input wire logic [NUM-1:0] serial_receive_line_i,
    output logic [NUM-1:0] serial_transmit_line_o,
    output logic [NUM-1:0] serial_receive_active_o,
    input wire logic [NUM-1:0] ring_indicator_n_i,
    output logic [NUM-1:0] terminal_ready_n_o,
    output logic [NUM-1:0] request_to_send_n_o,
    // Interrupt pins
    input wire logic irq_force_enable_i,
    output logic [NUM-1:0] channel_irq_out_o,
    output logic [NUM-1:0] channel_irq_out_oe_o,
    output logic combined_rx_ready_n_o,
    // Receive byte intake per channel
    input wire logic [NUM-1:0] rx_byte_valid_i,
    input wire logic [NUM*DATA_W-1:0] rx_byte_i,
    input wire logic [NUM-1:0] rx_error_i,
    input wire logic [NUM-1:0] rx_timeout_i,
    output logic [NUM-1:0] rx_byte_ready_o,
    // Transmit side status and data
    input wire logic [NUM-1:0] tx_empty_i,
    output logic [NUM-1:0] tx_serial_data_i_unused_o,
    output logic [NUM-1:0] tx_write_o,
    output logic [DATA_W-1:0] tx_data_o,
    output logic [NUM-1:0] auto_rts_active_o
);
    initial begin
        if (NUM < 1 || NUM > 8 || DEPTH != FIFO_DEPTH) begin
            $error("bad parameters");
        end
    end

    typedef struct packed {
        logic [DATA_W-1:0] modem_control_reg;
        logic [DATA_W-1:0] interrupt_enable_reg;
        logic [DATA_W-1:0] enhanced_feature_reg;
        logic [DATA_W-1:0] scratch;
        logic ring_q;
        logic modem_flag;
        logic error_flag;
        logic timeout_flag;
        logic rx_ready;
    } chan_type;

    typedef struct packed {
        chan_type [NUM-1:0] ch;
        logic rd_q;
        logic wr_q;
        logic [DATA_W-1:0] rdata;
        logic [NUM-1:0] tx_write;
        logic [DATA_W-1:0] tx_data;
        logic [NUM-1:0] irq;
        logic [NUM-1:0] irq_oe;
    } top_state_type;

    top_state_type state_q;
    top_state_type state_d;
    logic [NUM-1:0] fifo_out_valid;
    logic [NUM*DATA_W-1:0] fifo_out_data;
    logic [NUM-1:0] fifo_pop;
    logic [NUM*6-1:0] fifo_level;
    logic [NUM-1:0] loop_line;
    logic [NUM-1:0] rx_pin_eff;
    logic [NUM-1:0] rdy;

    // Receive byte buffer per channel
    genvar g;
    generate
        for (g = 0; g < NUM; g++) begin : g_ch
            fifo_if #(.WIDTH(DATA_W)) fport ();
            assign fport.in_valid = rx_byte_valid_i[g] && !device_reset_i;
            assign fport.in_data = rx_byte_i[g*DATA_W +: DATA_W];
            assign fport.out_ready = fifo_pop[g];
            assign rx_byte_ready_o[g] = fport.in_ready && !device_reset_i;
            assign fifo_out_valid[g] = fport.out_valid;
            assign fifo_out_data[g*DATA_W +: DATA_W] = fport.out_data;
            assign fifo_level[g*6 +: 6] = fport.level;
            rx_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
                .clk_sys_i(clk_sys_i),
                .arst_n_i(arst_n_i),
                .flush_i(device_reset_i),
                .port_io(fport.buffer)
            );
            // Loopback feeds back the idle transmit level
            assign loop_line[g] = 1'b1;
            assign rx_pin_eff[g] =
                state_q.ch[g].modem_control_reg[MC_LOOPBACK] ?
                loop_line[g] : serial_receive_line_i[g]; // RULE14
        end
    endgenerate

    logic rd_now;
    logic wr_now;
    logic [NUM-1:0] sel;
    assign sel = ~channel_select_n_i; // RULE17
    assign rd_now = !read_strobe_n_i && (sel != '0);
    assign wr_now = !write_strobe_n_i && (sel != '0);

    function automatic logic [DATA_W-1:0] read_reg(input chan_type c,
            input logic [DATA_W-1:0] fdata, input logic [5:0] lvl,
            input logic fval, input logic [2:0] addr, input logic tx_e,
            input logic ri_n, input logic rxp);
        logic [DATA_W-1:0] r;
        r = '0;
        unique case (addr)
            REG_DATA: r = fdata;
            REG_INT_ENABLE: r = c.interrupt_enable_reg;
            REG_INT_IDENT: r = {2'h0, lvl};
            REG_ENH_FEATURE: r = c.enhanced_feature_reg;
            REG_MODEM_CTRL: r = c.modem_control_reg;
            REG_LINE_STATUS: r = {1'b0, tx_e, tx_e, 3'h0, c.error_flag,
                fval};
            REG_MODEM_STATUS: r = {1'b0, !ri_n, 3'h0, rxp, c.modem_flag,
                1'b0};
            REG_SCRATCH: r = c.scratch;
        endcase
        return r;
    endfunction

    always_comb begin
        logic [5:0] lvl;
        logic pending;
        lvl = '0;
        pending = 1'b0;
        state_d = state_q;
        state_d.rd_q = rd_now;
        state_d.wr_q = wr_now;
        state_d.tx_write = '0;
        fifo_pop = '0;
        for (int i = 0; i < NUM; i++) begin
            lvl = fifo_level[i*6 +: 6];
            state_d.ch[i].ring_q = ring_indicator_n_i[i];
            // Low-to-high on the active-low ring line
            if (ring_indicator_n_i[i] && !state_q.ch[i].ring_q) begin
                state_d.ch[i].modem_flag = 1'b1; // RULE11
            end
            if (rx_error_i[i]) begin
                state_d.ch[i].error_flag = 1'b1;
            end
            if (rx_timeout_i[i]) begin
                state_d.ch[i].timeout_flag = 1'b1;
            end
            // Clear on read only at strobe start; a new event wins
            if (rd_now && !state_q.rd_q && sel[i]) begin
                if (reg_select_i == REG_MODEM_STATUS &&
                        !(ring_indicator_n_i[i] && !state_q.ch[i].ring_q))
                    begin
                    state_d.ch[i].modem_flag = 1'b0;
                end
                if (reg_select_i == REG_LINE_STATUS && !rx_error_i[i]) begin
                    state_d.ch[i].error_flag = 1'b0;
                end
                if (reg_select_i == REG_DATA) begin
                    fifo_pop[i] = fifo_out_valid[i];
                    if (!rx_timeout_i[i]) begin
                        state_d.ch[i].timeout_flag = 1'b0;
                    end
                end
            end
            // Ready: trigger or timeout, until empty
            if (lvl >= RX_TRIGGER_RST || state_q.ch[i].timeout_flag) begin
                state_d.ch[i].rx_ready = 1'b1; // RULE16
            end else if (lvl == '0) begin
                state_d.ch[i].rx_ready = 1'b0; // RULE16
            end
            // Store on write strobe fall
            if (wr_now && !state_q.wr_q && sel[i]) begin // RULE9
                unique case (reg_select_i)
                    REG_DATA: state_d.tx_write[i] = 1'b1;
                    REG_INT_ENABLE:
                        state_d.ch[i].interrupt_enable_reg = data_bus_i;
                    REG_ENH_FEATURE:
                        state_d.ch[i].enhanced_feature_reg = data_bus_i;
                    REG_MODEM_CTRL:
                        state_d.ch[i].modem_control_reg = data_bus_i;
                    REG_SCRATCH: state_d.ch[i].scratch = data_bus_i;
                    default: ;
                endcase
            end
            pending =
                (state_q.ch[i].interrupt_enable_reg[IE_RX_ERROR] &&
                 state_q.ch[i].error_flag) ||
                (state_q.ch[i].interrupt_enable_reg[IE_RX_DATA] &&
                 (fifo_out_valid[i] || state_q.ch[i].timeout_flag)) ||
                (state_q.ch[i].interrupt_enable_reg[IE_TX_EMPTY] &&
                 tx_empty_i[i]) ||
                (state_q.ch[i].interrupt_enable_reg[IE_MODEM] &&
                 state_q.ch[i].modem_flag); // RULE5
            state_d.irq_oe[i] = irq_force_enable_i ||
                state_q.ch[i].modem_control_reg[MC_IRQ_EN]; // RULE7
            state_d.irq[i] = pending &&
                (irq_force_enable_i ||
                 state_q.ch[i].modem_control_reg[MC_IRQ_EN]); // RULE4 RULE18
        end
        if (wr_now && !state_q.wr_q) begin
            state_d.tx_data = data_bus_i;
        end
        // Latch once per strobe so a pop cannot change the data shown
        if (rd_now && !state_q.rd_q) begin
            state_d.rdata = '0;
            for (int i = 0; i < NUM; i++) begin
                if (sel[i]) begin
                    state_d.rdata = state_d.rdata | read_reg(state_q.ch[i],
                        fifo_out_data[i*DATA_W +: DATA_W],
                        fifo_level[i*6 +: 6], fifo_out_valid[i],
                        reg_select_i, tx_empty_i[i],
                        ring_indicator_n_i[i], rx_pin_eff[i]); // RULE8
                end
            end
        end
        if (device_reset_i) begin
            state_d = '0; // RULE10
            for (int i = 0; i < NUM; i++) begin
                state_d.ch[i].modem_control_reg = MODEM_CTRL_RST;
                state_d.ch[i].interrupt_enable_reg = INT_ENABLE_RST;
                state_d.ch[i].enhanced_feature_reg = ENH_FEATURE_RST;
                state_d.ch[i].ring_q = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs
    assign data_bus_o = state_q.rdata; // RULE1
    assign data_bus_oe_o = rd_now && state_q.rd_q; // RULE8
    generate
        for (g = 0; g < NUM; g++) begin : g_out
            // RS-485: pin keys an external driver
            assign terminal_ready_n_o[g] =
                state_q.ch[g].enhanced_feature_reg[EF_RS485] ?
                !(!tx_empty_i[g] || state_q.tx_write[g]) : // RULE3
                !state_q.ch[g].modem_control_reg[MC_TERM_READY]; // RULE2
            assign request_to_send_n_o[g] =
                !state_q.ch[g].modem_control_reg[MC_REQ_SEND]; // RULE12
            assign auto_rts_active_o[g] =
                state_q.ch[g].enhanced_feature_reg[EF_AUTO_RTS]; // RULE13
            assign serial_transmit_line_o[g] = 1'b1;
            assign serial_receive_active_o[g] = !device_reset_i &&
                !state_q.ch[g].modem_control_reg[MC_LOOPBACK]; // RULE10
            assign tx_serial_data_i_unused_o[g] = rx_pin_eff[g];
            assign rdy[g] = state_q.ch[g].rx_ready;
        end
    endgenerate
    assign channel_irq_out_o = state_q.irq;
    assign channel_irq_out_oe_o = state_q.irq_oe; // RULE6
    assign combined_rx_ready_n_o = ~|rdy; // RULE16
    assign tx_write_o = state_q.tx_write;
    assign tx_data_o = state_q.tx_data;
endmodule // uart_host_port_modem_pins

// ### design/quad_port_pkg.sv
// Purpose: Shared constants for the four-channel host port block
// Assumes: Single 50 MHz clock, asynchronous active-low reset
// Notes: Indices are the three address bits
package quad_port_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int FIFO_DEPTH = 32;
    // Register indices on the three address bits
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_INT_ENABLE = 3'h1;
    localparam logic [2:0] REG_INT_IDENT = 3'h2;
    localparam logic [2:0] REG_ENH_FEATURE = 3'h3;
    localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
    localparam logic [2:0] REG_LINE_STATUS = 3'h5;
    localparam logic [2:0] REG_MODEM_STATUS = 3'h6;
    localparam logic [2:0] REG_SCRATCH = 3'h7;
    // Modem control fields
    localparam int MC_TERM_READY = 0;
    localparam int MC_REQ_SEND = 1;
    localparam int MC_IRQ_EN = 3;
    localparam int MC_LOOPBACK = 4;
    // Enhanced feature fields
    localparam int EF_AUTO_RTS = 6;
    localparam int EF_RS485 = 5;
    // Interrupt enable fields
    localparam int IE_RX_DATA = 0;
    localparam int IE_TX_EMPTY = 1;
    localparam int IE_RX_ERROR = 2;
    localparam int IE_MODEM = 3;
    // Reset values
    localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
    localparam logic [7:0] INT_ENABLE_RST = 8'h00;
    localparam logic [7:0] ENH_FEATURE_RST = 8'h00;
    localparam logic [5:0] RX_TRIGGER_RST = 6'h01;
endpackage

// ### design/fifo_if.sv
// Purpose: Valid/ready carrier between host port and receive buffer
// Assumes: One clock domain
// Notes: Width is set at instantiation
`timescale 1ns/100ps
interface fifo_if #(parameter int WIDTH = 8) ();
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    logic [5:0] level;
    modport producer(output in_valid, output in_data, input in_ready,
        input out_valid, input out_data, output out_ready, input level);
    modport buffer(input in_valid, input in_data, output in_ready,
        output out_valid, output out_data, input out_ready, output level);
endinterface

// ### design/rx_fifo.sv
// Purpose: Receive byte buffer with valid/ready on both sides
// Assumes: DEPTH a power of two, at most 32 so level fits six bits
// Notes: Read data comes from a register
`timescale 1ns/100ps
module rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic flush_i,
    // Buffer ports
    fifo_if.buffer port_io
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || DEPTH > 32 || (1 << AW) != DEPTH) begin
            $error("bad depth");
        end
    end
    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
        logic [WIDTH-1:0] out_data;
        logic out_valid;
    } fifo_state_type;
    fifo_state_type state_q;
    fifo_state_type state_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] count;
    logic full;
    logic empty;
    logic push;
    logic pop;
    assign count = state_q.wr_ptr - state_q.rd_ptr;
    assign full = count == (AW+1)'(DEPTH);
    assign empty = count == '0;
    assign push = port_io.in_valid && !full;
    assign pop = !empty && (!state_q.out_valid || port_io.out_ready);
    assign port_io.in_ready = !full;
    assign port_io.out_valid = state_q.out_valid;
    assign port_io.out_data = state_q.out_data;
    assign port_io.level = 6'(count) + 6'(state_q.out_valid);
    always_comb begin
        state_d = state_q;
        if (port_io.out_ready && state_q.out_valid) begin
            state_d.out_valid = 1'b0;
        end
        if (pop) begin
            state_d.out_data = mem_q[state_q.rd_ptr[AW-1:0]];
            state_d.out_valid = 1'b1;
            state_d.rd_ptr = state_q.rd_ptr + 1'b1;
        end
        if (push) begin
            state_d.wr_ptr = state_q.wr_ptr + 1'b1;
        end
        if (flush_i) begin
            state_d = '0;
        end
    end
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[state_q.wr_ptr[AW-1:0]] <= port_io.in_data;
        end
    end
endmodule // rx_fifo

// ### test/uart_host_port_props.sv
// Purpose: Port checks for the host port block
// Assumes: Bound into the top module
// Notes: Channel 0 stands for all
`timescale 1ns/100ps
module uart_host_port_props
    import quad_port_pkg::*;
#(
    parameter int NUM = NUM_CH
) (
    // Clock and resets
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic device_reset_i,
    // Host port
    input wire logic [NUM-1:0] channel_select_n_i,
    input wire logic [ADDR_W-1:0] reg_select_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [DATA_W-1:0] data_bus_i,
    input wire logic data_bus_oe_o,
    // Pins
    input wire logic [NUM-1:0] serial_receive_active_o,
    input wire logic [NUM-1:0] terminal_ready_n_o,
    input wire logic [NUM-1:0] request_to_send_n_o,
    input wire logic irq_force_enable_i,
    input wire logic [NUM-1:0] channel_irq_out_o,
    input wire logic [NUM-1:0] channel_irq_out_oe_o,
    input wire logic combined_rx_ready_n_o,
    input wire logic [NUM-1:0] auto_rts_active_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence wr0(logic [2:0] a);
        $fell(write_strobe_n_i) && !channel_select_n_i[0] &&
            reg_select_i == a && !device_reset_i;
    endsequence

    a_dtr_write: assert property (wr0(REG_MODEM_CTRL) |=>
        terminal_ready_n_o[0] == !$past(data_bus_i[MC_TERM_READY]))
        else $error("dtr mismatch");
    a_rts_write: assert property (wr0(REG_MODEM_CTRL) |=>
        request_to_send_n_o[0] == !$past(data_bus_i[MC_REQ_SEND]))
        else $error("rts mismatch");
    a_auto_rts_write: assert property (wr0(REG_ENH_FEATURE) |=>
        auto_rts_active_o[0] == $past(data_bus_i[EF_AUTO_RTS]))
        else $error("auto rts mismatch");
    a_reset_pins_high: assert property (device_reset_i |=>
        terminal_ready_n_o == '1 && request_to_send_n_o == '1)
        else $error("modem pins low");
    a_irq_hiz_reset: assert property (
        (device_reset_i && !irq_force_enable_i)[*2] |=>
        channel_irq_out_oe_o == '0)
        else $error("irq driven");
    a_force_drives_irq: assert property (
        (irq_force_enable_i && !device_reset_i)[*2] |->
        channel_irq_out_oe_o == '1)
        else $error("irq not forced");
    a_bus_idle_off: assert property (read_strobe_n_i |->
        !data_bus_oe_o)
        else $error("bus driven");
    a_read_drives_bus: assert property (
        (!read_strobe_n_i && !(&channel_select_n_i))[*2] |->
        data_bus_oe_o)
        else $error("bus not driven");
    a_rx_off_reset: assert property (device_reset_i[*2] |->
        serial_receive_active_o == '0)
        else $error("rx active");

    c_write: cover property (wr0(REG_MODEM_CTRL));
    c_irq: cover property (|channel_irq_out_o);
    c_rx_ready: cover property (!combined_rx_ready_n_o);
    c_force: cover property (irq_force_enable_i);
endmodule // uart_host_port_props

bind uart_host_port_modem_pins uart_host_port_props #(.NUM(NUM)) u_props (.*);

// ### test/modem_far_end.sv
// Purpose: Far-end model feeding received bytes and the receive pins
// Assumes: One channel is fed at a time
// Notes: Stall slows the far end
`timescale 1ns/100ps
module modem_far_end (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Bench control
    input wire logic load_i,
    input wire logic [7:0] load_data_i,
    input wire logic [1:0] chan_i,
    input wire logic stall_i,
    // Design side
    input wire logic [3:0] ready_i,
    output logic [3:0] valid_o,
    output logic [31:0] data_o,
    output logic [3:0] line_o
);
    logic [7:0] q[$];
    logic take;
    assign line_o = 4'hF;
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q.delete();
            valid_o <= 4'h0;
            data_o <= 32'hFFFFFFFF;
        end else begin
            take = valid_o[chan_i] && ready_i[chan_i];
            if (take) begin
                void'(q.pop_front());
            end
            if (load_i) begin
                q.push_back(load_data_i);
            end
            // An offer stays unchanged until it is taken
            if (take || valid_o == 4'h0) begin
                if (q.size() != 0 && !stall_i) begin
                    valid_o <= 4'h1 << chan_i;
                    data_o <= {4{q[0]}};
                end else begin
                    valid_o <= 4'h0;
                    data_o <= ~data_o;
                end
            end
        end
    end
endmodule // modem_far_end

// ### test/test_uart_host_port_modem_pins.sv
// Purpose: Self-checking bench for the four-channel host port block
// Assumes: Random data from a fixed-seed xorshift
// Notes: Channel 0 carries receive traffic
`timescale 1ns/100ps
module test_uart_host_port_modem_pins;
    import quad_port_pkg::*;
    logic clk_sys_i = 1'b0;
    logic arst_n_i, device_reset_i, read_strobe_n_i, write_strobe_n_i;
    logic irq_force_enable_i, data_bus_oe_o, combined_rx_ready_n_o;
    logic ld, stall;
    logic [1:0] chan;
    logic [2:0] reg_select_i;
    logic [7:0] data_bus_i, data_bus_o, ld_d, g, d, e;
    logic [31:0] rx_byte_i, seed = 32'hDB296A1A;
    logic [3:0] channel_select_n_i, ring_indicator_n_i, rx_error_i;
    logic [3:0] rx_timeout_i, tx_empty_i, serial_receive_line_i, ef;
    logic [3:0] rx_byte_valid_i, rx_byte_ready_o, terminal_ready_n_o;
    logic [3:0] request_to_send_n_o, channel_irq_out_o;
    logic [3:0] channel_irq_out_oe_o, serial_receive_active_o;
    logic [3:0] auto_rts_active_o;
    logic [7:0] mc [4];
    logic [7:0] exp_q[$];
    int err_count = 0;
    int total_checks = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    uart_host_port_modem_pins uut (.*, .serial_transmit_line_o(),
        .tx_serial_data_i_unused_o(), .tx_write_o(), .tx_data_o());
    modem_far_end far (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .load_i(ld), .load_data_i(ld_d), .chan_i(chan), .stall_i(stall),
        .ready_i(rx_byte_ready_o), .valid_o(rx_byte_valid_i),
        .data_o(rx_byte_i), .line_o(serial_receive_line_i));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected active-low pin per channel
    function automatic logic [3:0] col(int b);
        for (int c = 0; c < 4; c++) begin
            col[c] = ~mc[c][b];
        end
    endfunction

    task automatic tick(int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic chk4(string n, logic [7:0] x, logic [7:0] y);
        total_checks++;
        if (y !== x) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, x, y);
        end
    endtask
    task automatic wr(logic [3:0] s, logic [2:0] a, logic [7:0] v);
        channel_select_n_i <= s;
        reg_select_i <= a;
        data_bus_i <= v;
        write_strobe_n_i <= 1'b0;
        tick(1);
        write_strobe_n_i <= 1'b1;
        channel_select_n_i <= 4'hF;
        tick(2);
    endtask
    task automatic rd(int c, logic [2:0] a, output logic [7:0] v);
        channel_select_n_i <= ~(4'h1 << c);
        reg_select_i <= a;
        read_strobe_n_i <= 1'b0;
        tick(2);
        v = data_bus_o;
        read_strobe_n_i <= 1'b1;
        channel_select_n_i <= 4'hF;
        tick(2);
    endtask
    task automatic dreset();
        device_reset_i <= 1'b1;
        tick(3);
        device_reset_i <= 1'b0;
        tick(1);
        mc = '{default: 8'h00};
        ef = 4'h0;
        chk4("terminal ready", 4'hF, terminal_ready_n_o);
        chk4("request to send", 4'hF, request_to_send_n_o);
        chk4("irq enable", 4'h0, channel_irq_out_oe_o);
        chk4("auto rts", 4'h0, auto_rts_active_o);
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        end_of_test();
    end

    initial begin
        int c;
        arst_n_i = 1'b0;
        device_reset_i = 1'b1;
        read_strobe_n_i = 1'b1;
        write_strobe_n_i = 1'b1;
        irq_force_enable_i = 1'b0;
        channel_select_n_i = 4'hF;
        reg_select_i = 3'h0;
        data_bus_i = 8'h00;
        ring_indicator_n_i = 4'hF;
        {rx_error_i, rx_timeout_i, tx_empty_i} = 12'h000;
        {ld, stall, chan, ld_d} = 12'h000;
        tick(16);
        arst_n_i <= 1'b1;
        tick(2);
        dreset();
        for (int i = 0; i < 16; i++) begin
            c = rnd() % 4;
            d = rnd();
            wr(~(4'h1 << c), REG_MODEM_CTRL, d);
            mc[c] = d;
            chk4("terminal ready", col(0), terminal_ready_n_o);
            chk4("request to send", col(1), request_to_send_n_o);
            chk4("rx active", col(4), serial_receive_active_o);
            wr(4'hF, REG_MODEM_CTRL, ~d);
            chk4("unselected", col(0), terminal_ready_n_o);
            e = rnd() & 8'hDF;
            wr(~(4'h1 << c), REG_ENH_FEATURE, e);
            ef[c] = e[EF_AUTO_RTS];
            chk4("auto rts", ef, auto_rts_active_o);
            e = rnd();
            wr(~(4'h1 << c), REG_SCRATCH, e);
            rd(c, REG_SCRATCH, g);
            chk4("scratch", e, g);
        end
        $display("done: registers");
        dreset();
        for (int s = 1; s < 4; s++) begin
            wr(~(4'h1 << s), REG_INT_ENABLE, 8'h01 << s);
            wr(~(4'h1 << s), REG_MODEM_CTRL, 8'h08);
            chk4("idle irq", 4'h0, channel_irq_out_o);
            tx_empty_i[1] <= (s == 1);
            rx_error_i[2] <= (s == 2);
            ring_indicator_n_i[3] <= (s != 3);
            tick(1);
            rx_error_i <= 4'h0;
            ring_indicator_n_i <= 4'hF;
            tick(4);
            chk4("irq level", 4'h1 << s, channel_irq_out_o);
            chk4("irq enable", 4'h1 << s, channel_irq_out_oe_o);
            wr(~(4'h1 << s), REG_MODEM_CTRL, 8'h00);
            chk4("irq disabled", 4'h0, channel_irq_out_oe_o);
            irq_force_enable_i <= 1'b1;
            tick(3);
            chk4("irq forced", 4'hF, channel_irq_out_oe_o);
            irq_force_enable_i <= 1'b0;
            wr(~(4'h1 << s), REG_MODEM_CTRL, 8'h08);
            tx_empty_i <= 4'h0;
            rd(s, s == 2 ? REG_LINE_STATUS : REG_MODEM_STATUS, g);
            tick(3);
            chk4("irq cleared", 4'h0, channel_irq_out_o);
            wr(~(4'h1 << s), REG_MODEM_CTRL, 8'h00);
        end
        $display("done: irq");
        dreset();
        wr(4'hE, REG_INT_ENABLE, 8'h01);
        wr(4'hE, REG_MODEM_CTRL, 8'h08);
        chk4("rx ready", 4'h1, {3'h0, combined_rx_ready_n_o});
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            d = rnd();
            exp_q.push_back(d);
            ld <= 1'b1;
            ld_d <= d;
            stall <= d[7];
            tick(1);
        end
        ld <= 1'b0;
        stall <= 1'b0;
        for (int k = 0; k < 300 && rx_byte_ready_o[0] !== 1'b0; k++) begin
            tick(1);
        end
        tick(2);
        chk4("intake ready", 4'hE, rx_byte_ready_o);
        chk4("rx ready", 4'h0, {3'h0, combined_rx_ready_n_o});
        chk4("rx irq", 4'h1, channel_irq_out_o);
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            rd(0, REG_DATA, g);
            chk4("rx byte", exp_q.pop_front(), g);
        end
        tick(3);
        chk4("rx ready", 4'h1, {3'h0, combined_rx_ready_n_o});
        chk4("rx irq", 4'h0, channel_irq_out_o);
        $display("done: rx");
        dreset();
        end_of_test();
    end
endmodule // test_uart_host_port_modem_pins
